/* File: src/pmbus_vout_setpoint_regs.sv */
// per-page output-voltage setpoint registers with effective target computation
// assumes a bus front end that decodes frames into command-level strobes on ref_clk_in
`include "vout_setpoint_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pmbus_vout_setpoint_regs #(
  parameter int unsigned PAGES = 2
)(
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  // command port from bus front end
  input  wire logic        cmd_wr_in,
  input  wire logic        cmd_rd_in,
  input  wire logic [7:0]  cmd_code_in,
  input  wire logic [15:0] cmd_wdata_in,
  input  wire logic [7:0]  page_sel_in,
  output logic      [15:0] cmd_rdata_out,
  output logic             cmd_rvalid_out,
  output logic             cmd_hit_out,
  // run control source bits, one byte per page
  input  wire logic [7:0]  run_ctrl0_in,
  input  wire logic [7:0]  run_ctrl1_in,
  // regulation targets
  output logic      [15:0] target0_out,
  output logic      [15:0] target1_out,
  output logic      [15:0] slew0_out,
  output logic      [15:0] slew1_out
);

  logic rst_s1_q;
  logic rst_s2_q;

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  wire logic rst_n = rst_s2_q;

  // page decode; unknown page values reach no copy
  logic [PAGES-1:0] page_hit;
  always_comb
  begin
    page_hit = '0;
    case (page_sel_in)
      `PAGE_OUT0: page_hit = 2'b01;
      `PAGE_OUT1: page_hit = 2'b10;
      `PAGE_BOTH: page_hit = 2'b11;
      default:    page_hit = 2'b00;
    endcase
  end

  logic [15:0] nom_q   [PAGES];
  logic [15:0] ofs_q   [PAGES];
  logic [15:0] ceil_q  [PAGES];
  logic [15:0] mhi_q   [PAGES];
  logic [15:0] mlo_q   [PAGES];
  logic [15:0] slew_q  [PAGES];
  logic [15:0] act_q   [PAGES];
  logic [15:0] tgt_q   [PAGES];
  logic [7:0]  run_ctrl [PAGES];

  assign run_ctrl[0] = run_ctrl0_in;
  assign run_ctrl[1] = run_ctrl1_in;

  genvar g;
  generate
    for (g = 0; g < PAGES; g++)
    begin : page_g
      logic [15:0] nom_d;
      logic [15:0] ofs_d;
      logic [15:0] ceil_d;
      logic [15:0] mhi_d;
      logic [15:0] mlo_d;
      logic [15:0] slew_d;
      logic [15:0] act_d;
      logic [15:0] tgt_d;
      logic [15:0] src_val;
      logic signed [17:0] sum;
      logic        wr;
      vout_setpoint_pkg::target_src_t src;

      always_comb
      begin
        wr     = cmd_wr_in && page_hit[g];
        nom_d  = nom_q[g];
        ofs_d  = ofs_q[g];
        ceil_d = ceil_q[g];
        mhi_d  = mhi_q[g];
        mlo_d  = mlo_q[g];
        slew_d = slew_q[g];
        if (wr)
        begin
          case (cmd_code_in)
            `CMD_NOMINAL:      nom_d = cmd_wdata_in;
            // out-of-span trim or ceiling is dropped, old value kept
            `CMD_OFFSET:
            begin
              if ($signed(cmd_wdata_in) <= $signed(`OFFSET_SPAN_MV)
                  && $signed(cmd_wdata_in) >= -$signed(`OFFSET_SPAN_MV))
              begin
                ofs_d = cmd_wdata_in;
              end
            end
            `CMD_CEILING:
            begin
              if (cmd_wdata_in <= `CEILING_SPAN_MV)
              begin
                ceil_d = cmd_wdata_in;
              end
            end
            `CMD_UPPER_MARGIN: mhi_d = cmd_wdata_in;
            `CMD_LOWER_MARGIN: mlo_d = cmd_wdata_in;
            `CMD_SLEW_RATE:    slew_d = cmd_wdata_in;
            default:           nom_d = nom_q[g];
          endcase
        end
      end

      // active rate group; only the commit strobe moves it, so a
      // half-finished reprogramming never reaches the regulator
      always_comb
      begin
        act_d = act_q[g];
        if (wr && cmd_code_in == `CMD_COMMIT)
        begin
          act_d = slew_q[g];
        end
      end

      always_ff @(posedge ref_clk_in or negedge rst_n)
      begin
        if (!rst_n)
        begin
          act_q[g] <= `RST_SLEW_RATE;
        end
        else
        begin
          act_q[g] <= act_d;
        end
      end

      // target group: source pick, trim, clamp
      always_comb
      begin
        src     = vout_setpoint_pkg::target_src_t'(run_ctrl[g][`SRC_MSB:`SRC_LSB]);
        src_val = nom_q[g];
        case (src)
          vout_setpoint_pkg::SRC_NOMINAL:     src_val = nom_q[g];
          vout_setpoint_pkg::SRC_MARGIN_LOW:  src_val = mlo_q[g];
          vout_setpoint_pkg::SRC_MARGIN_HIGH: src_val = mhi_q[g];
          // unused code holds the nominal target rather than jumping
          default:                            src_val = nom_q[g];
        endcase
        // 18 bits so a full-scale source plus trim cannot wrap
        sum = $signed({2'b00, src_val}) + $signed({{2{ofs_q[g][15]}}, ofs_q[g]});
        // no floor here: a negative sum simply stops at zero
        if (sum < 0)
        begin
          tgt_d = 16'h0000;
        end
        else if (sum > $signed({2'b00, ceil_q[g]}))
        begin
          tgt_d = ceil_q[g];
        end
        else
        begin
          tgt_d = sum[15:0];
        end
      end

      // registered so the regulation loop sees one clean word per edge
      always_ff @(posedge ref_clk_in or negedge rst_n)
      begin
        if (!rst_n)
        begin
          tgt_q[g] <= `RST_NOMINAL;
        end
        else
        begin
          tgt_q[g] <= tgt_d;
        end
      end

      always_ff @(posedge ref_clk_in or negedge rst_n)
      begin
        if (!rst_n)
        begin
          nom_q[g]  <= `RST_NOMINAL;
          ofs_q[g]  <= `RST_OFFSET;
          ceil_q[g] <= `RST_CEILING;
          mhi_q[g]  <= `RST_UPPER_MARGIN;
          mlo_q[g]  <= `RST_LOWER_MARGIN;
          slew_q[g] <= `RST_SLEW_RATE;
        end
        else
        begin
          nom_q[g]  <= nom_d;
          ofs_q[g]  <= ofs_d;
          ceil_q[g] <= ceil_d;
          mhi_q[g]  <= mhi_d;
          mlo_q[g]  <= mlo_d;
          slew_q[g] <= slew_d;
        end
      end
    end
  endgenerate

  // read side: page FFh reads back output 0's copy
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;
  logic        rvalid_d;
  logic        rvalid_q;
  logic        hit;
  int unsigned rp;

  // known-code flag, decoded apart from the read mux
  always_comb
  begin
    hit = 1'b1;
    case (cmd_code_in)
      `CMD_FORMAT_QUERY: hit = 1'b1;
      `CMD_NOMINAL:      hit = 1'b1;
      `CMD_OFFSET:       hit = 1'b1;
      `CMD_CEILING:      hit = 1'b1;
      `CMD_UPPER_MARGIN: hit = 1'b1;
      `CMD_LOWER_MARGIN: hit = 1'b1;
      `CMD_SLEW_RATE:    hit = 1'b1;
      `CMD_COMMIT:       hit = 1'b1;
      default:           hit = 1'b0;
    endcase
  end

  // read mux; data held between reads so a slow host can pick it up late
  always_comb
  begin
    rp       = (page_sel_in == `PAGE_OUT1) ? 1 : 0;
    rdata_d  = rdata_q;
    rvalid_d = cmd_rd_in;
    if (cmd_rd_in)
    begin
      case (cmd_code_in)
        `CMD_FORMAT_QUERY: rdata_d = {8'h00, `FORMAT_QUERY_VAL};
        `CMD_NOMINAL:      rdata_d = nom_q[rp];
        `CMD_OFFSET:       rdata_d = ofs_q[rp];
        `CMD_CEILING:      rdata_d = ceil_q[rp];
        `CMD_UPPER_MARGIN: rdata_d = mhi_q[rp];
        `CMD_LOWER_MARGIN: rdata_d = mlo_q[rp];
        `CMD_SLEW_RATE:    rdata_d = slew_q[rp];
        default:           rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign cmd_rdata_out  = rdata_q;
  assign cmd_rvalid_out = rvalid_q;
  assign cmd_hit_out    = hit;
  assign target0_out    = tgt_q[0];
  assign target1_out    = tgt_q[1];
  assign slew0_out      = act_q[0];
  assign slew1_out      = act_q[1];

endmodule

`default_nettype wire

/* File: src/vout_setpoint_consts.svh */
// constants for the output-setpoint register bank: command codes, resets, field positions
// assumes a command-level register port from the bus front end
// Notes on behaviour
// - The mode query is one global read-only byte that always reads 40h, meaning direct format only.
// - The nominal target is 16-bit unsigned millivolts, resets to 900 mV, and drives the target when nominal is selected.
// - The trim is a 16-bit signed millivolt offset, resets to zero, is added to the target, and spans plus or minus 250 mV.
// - The ceiling is 16-bit unsigned millivolts, resets to 2300 mV, caps the target, and accepts 0 to 2850 mV.
// - The high margin is 16-bit unsigned millivolts, resets to 1600 mV, and is the target when margin high is selected.
// - The low margin is 16-bit unsigned millivolts, resets to 250 mV, and is the target when margin low is selected.
// - The slew register counts 100 uV/us units, resets to 10 mV/us, and sets how fast the target moves.
// - A written slew value stays inactive until the commit-settings command loads it into the active rate.
// - Every setting but the mode query is two bytes and kept per output page; writes reach the selected page, a read of FFh returns output 0's copy.
// - Page 00h selects output 0, 01h output 1, and FFh both outputs.
// - Run-control bits 5:4 pick nominal (00), margin low (01), margin high (10); 11 is unused.
// - Every transfer to or from these registers but the mode query carries a two-byte binary integer.
`ifndef VOUT_SETPOINT_CONSTS_SVH
`define VOUT_SETPOINT_CONSTS_SVH

`define CMD_FORMAT_QUERY   8'h20
`define CMD_NOMINAL        8'h21
`define CMD_OFFSET         8'h22
`define CMD_CEILING        8'h24
`define CMD_UPPER_MARGIN   8'h25
`define CMD_LOWER_MARGIN   8'h26
`define CMD_SLEW_RATE      8'h27
`define CMD_COMMIT         8'hE7

`define FORMAT_QUERY_VAL   8'h40
`define RST_NOMINAL        16'h0384
`define RST_OFFSET         16'h0000
`define RST_CEILING        16'h08FC
`define RST_UPPER_MARGIN   16'h0640
`define RST_LOWER_MARGIN   16'h00FA
`define RST_SLEW_RATE      16'h0064

`define OFFSET_SPAN_MV     16'h00FA
`define CEILING_SPAN_MV    16'h0B22

`define PAGE_OUT0          8'h00
`define PAGE_OUT1          8'h01
`define PAGE_BOTH          8'hFF

`define SRC_LSB            4
`define SRC_MSB            5

`endif

/* File: src/vout_setpoint_pkg.sv */
// types for the output-setpoint register bank
// assumes the constants header sits beside it
package vout_setpoint_pkg;
  typedef enum logic [1:0] {
    SRC_NOMINAL,
    SRC_MARGIN_LOW,
    SRC_MARGIN_HIGH,
    SRC_UNUSED
  } target_src_t;
endpackage

/* File: test/tb_top.sv */
// bench for the setpoint register bank
// assumes the host model is the only driver of the command port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        ref_clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        cmd_wr_in, cmd_rd_in, cmd_rvalid_out, cmd_hit_out;
  logic [7:0]  cmd_code_in, page_sel_in, run_ctrl0_in = 8'h00, run_ctrl1_in = 8'h00;
  logic [15:0] cmd_wdata_in, cmd_rdata_out, target0_out, target1_out, slew0_out, slew1_out, q;
  int          num_errors = 0;
  int          checks = 0;
  // page, code, write data, read-back; refused writes keep the old value
  logic [47:0] rows [9] = '{48'h00_21_03E8_03E8, 48'h00_22_FF06_FF06, 48'h00_22_00FB_FF06,
    48'h00_22_FFCE_FFCE, 48'h00_24_0B23_08FC, 48'h00_24_0B22_0B22, 48'h00_20_1234_0040,
    48'h01_21_0123_0123, 48'hFF_26_0100_0100};
  logic [23:0] resets [7] = '{24'h20_0040, 24'h21_0384, 24'h22_0000, 24'h24_08FC,
    24'h25_0640, 24'h26_00FA, 24'h27_0064};
  logic [15:0] srcs [4] = '{16'h03B6, 16'h00CE, 16'h060E, 16'h03B6};
  always #2.5 ref_clk_in = ~ref_clk_in;
  pmbus_vout_setpoint_regs dut (.*);
  vout_host host (.clk_in(ref_clk_in), .rdata_in(cmd_rdata_out), .wr_out(cmd_wr_in),
    .rd_out(cmd_rd_in), .page_out(page_sel_in), .code_out(cmd_code_in), .wdata_out(cmd_wdata_in));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("mismatches %0d, comparisons %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic settle;
    repeat (3) @(posedge ref_clk_in);
    #1;
  endtask
  initial
  begin
    #100us;
    num_errors++;
    give_verdict;
  end
  initial
  begin
    repeat (16) @(posedge ref_clk_in);
    #1 rst_b_in = 1'b1;
    settle;
    check(target0_out, 16'h0384);
    foreach (resets[i])
    begin
      host.xfer(1'b0, 8'h01, resets[i][23:16], 16'h0000, q);
      check(q, resets[i][15:0]);
    end
    foreach (rows[i])
    begin
      host.xfer(1'b1, rows[i][47:40], rows[i][39:32], rows[i][31:16], q);
      host.xfer(1'b0, rows[i][47:40], rows[i][39:32], 16'h0000, q);
      check(q, rows[i][15:0]);
    end
    host.xfer(1'b0, 8'h01, 8'h26, 16'h0000, q);
    check(q, 16'h0100);
    foreach (srcs[i])
    begin
      run_ctrl0_in = 8'(i << 4);
      settle;
      check(target0_out, srcs[i]);
    end
    check(target1_out, 16'h0123);
    run_ctrl0_in = 8'h20;
    host.xfer(1'b1, 8'h00, 8'h24, 16'h0500, q);
    settle;
    check(target0_out, 16'h0500);
    host.xfer(1'b1, 8'h00, 8'h27, 16'h0010, q);
    check(slew0_out, 16'h0064);
    host.xfer(1'b1, 8'h00, 8'hE7, 16'h0000, q);
    settle;
    check(slew0_out, 16'h0010);
    check(slew1_out, 16'h0064);
    rst_b_in = 1'b0;
    settle;
    check(slew0_out, 16'h0064);
    rst_b_in = 1'b1;
    settle;
    check(target0_out, 16'h0640);
    host.xfer(1'b0, 8'h00, 8'h21, 16'h0000, q);
    check(q, 16'h0384);
    host.xfer(1'b0, 8'h00, 8'h99, 16'h0000, q);
    check(q, 16'h0000);
    check(16'(cmd_hit_out), 16'h0000);
    check(16'(cmd_rvalid_out), 16'h0001);
    give_verdict;
  end
endmodule
`default_nettype wire

/* File: test/vout_host.sv */
// host model of the command port: one write or read per call
// assumes calls come from one process, after reset
`timescale 1ns/1ps
`default_nettype none
module vout_host (
  // clock and answer
  input  wire logic        clk_in,
  input  wire logic [15:0] rdata_in,
  // command strobes and data
  output logic             wr_out,
  output logic             rd_out,
  output logic      [7:0]  page_out,
  output logic      [7:0]  code_out,
  output logic      [15:0] wdata_out
);
  initial
  begin
    {wr_out, rd_out, page_out, code_out} = 18'h0;
    wdata_out = 16'h0000;
  end
  // one strobe cycle per call; read data sampled just after the edge that ends the strobe
  task automatic xfer(input logic w, input logic [7:0] p, input logic [7:0] c,
                      input logic [15:0] d, output logic [15:0] q);
    @(posedge clk_in);
    #1;
    {wr_out, rd_out, page_out, code_out} = {w, !w, p, c};
    wdata_out = d; // one two-byte word
    @(posedge clk_in);
    #1;
    {wr_out, rd_out} = 2'b00;
    wdata_out = ~d; // nothing holds released lines
    q = rdata_in;
  endtask
endmodule
`default_nettype wire

/* File: test/vout_setpoint_assertions.sv */
// checker bound to the setpoint register bank
// assumes commands two cycles apart, as the host model issues them
`include "vout_setpoint_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module vout_setpoint_checker (
  // ports watched
  input wire logic        ref_clk_in,
  input wire logic        rst_b_in,
  input wire logic        cmd_wr_in,
  input wire logic        cmd_rd_in,
  input wire logic [7:0]  cmd_code_in,
  input wire logic [15:0] cmd_wdata_in,
  input wire logic [7:0]  page_sel_in,
  input wire logic [15:0] cmd_rdata_out,
  input wire logic        cmd_rvalid_out,
  input wire logic [15:0] target0_out,
  input wire logic [15:0] target1_out,
  input wire logic [15:0] slew0_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_rd(c);
    cmd_rd_in && cmd_code_in == c;
  endsequence
  sequence s_wr0(c);
    cmd_wr_in && cmd_code_in == c && page_sel_in == `PAGE_OUT0;
  endsequence
  property p_rd; cmd_rvalid_out == $past(cmd_rd_in); endproperty
  a_rd: assert property (p_rd) else $error("read pulse wrong");
  property p_fmt; s_rd(`CMD_FORMAT_QUERY) |=> cmd_rdata_out == 16'h0040; endproperty
  a_fmt: assert property (p_fmt) else $error("mode query value");
  property p_trim;
    s_rd(`CMD_OFFSET) |=> $signed(cmd_rdata_out) inside {[-250:250]};
  endproperty
  a_trim: assert property (p_trim) else $error("trim out of span");
  property p_ceil; s_rd(`CMD_CEILING) |=> cmd_rdata_out <= 16'h0B22; endproperty
  a_ceil: assert property (p_ceil) else $error("ceiling out of span");
  property p_cap; target0_out <= 16'h0B22 && target1_out <= 16'h0B22; endproperty
  a_cap: assert property (p_cap) else $error("target above span");
  property p_hold;
    $changed(slew0_out) |-> $past(cmd_wr_in && cmd_code_in == `CMD_COMMIT);
  endproperty
  a_hold: assert property (p_hold) else $error("slew moved uncommitted");
  property p_commit;
    s_wr0(`CMD_SLEW_RATE) ##2 s_wr0(`CMD_COMMIT) |=> slew0_out == $past(cmd_wdata_in, 3);
  endproperty
  a_commit: assert property (p_commit) else $error("commit not loaded");
  property p_wrrd;
    s_wr0(`CMD_NOMINAL) ##2 s_rd(`CMD_NOMINAL) |=> cmd_rdata_out == $past(cmd_wdata_in, 3);
  endproperty
  a_wrrd: assert property (p_wrrd) else $error("read-back differs");
endmodule
bind pmbus_vout_setpoint_regs vout_setpoint_checker chk (.*);
`default_nettype wire
